// >>> rtl/wake_irq_device.sv
`default_nettype none
// How it works
// - eight port 0 pin wake enables
// - eight port 2 pin wake enables
// - eight port 3 pin wake enables
// - enables for PWM group and PWM0
// - enables for touch-key B and A
// - PWM1 period sets group flag, BFh clears
// - PWM0 period sets flag, DFh clears
// - touch-key B scan sets flag, FDh clears
// - touch-key A scan sets flag, FEh clears
module wake_irq_device (
    input wire logic clk,
    input wire logic resetn,
    sfr_if.device bus
);
    ////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic hits(input logic strobe, input logic [7:0] addr, input logic [7:0] offset);
        return strobe && addr == offset;
    endfunction : hits
    function automatic logic [3:0] pick_sources(input logic [7:0] value);
        logic [3:0] picked;
        picked[3] = value[wake_irq_pkg::pwm_group_bit];
        picked[2] = value[wake_irq_pkg::pwm_first_bit];
        picked[1] = value[wake_irq_pkg::touch_b_bit];
        picked[0] = value[wake_irq_pkg::touch_a_bit];
        return picked;
    endfunction : pick_sources
    function automatic logic [7:0] place_sources(input logic [3:0] sources);
        logic [7:0] placed;
        placed = 8'h00;
        placed[wake_irq_pkg::pwm_group_bit] = sources[3];
        placed[wake_irq_pkg::pwm_first_bit] = sources[2];
        placed[wake_irq_pkg::touch_b_bit] = sources[1];
        placed[wake_irq_pkg::touch_a_bit] = sources[0];
        return placed;
    endfunction : place_sources
    ////////////////////////////////////////////////////////////////
    // state and decodes
    logic [7:0] p0_q;
    logic [7:0] p0_d;
    logic [7:0] p2_q;
    logic [7:0] p2_d;
    logic [7:0] p3_q;
    logic [7:0] p3_d;
    logic [7:0] en_q;
    logic [7:0] en_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [3:0] irq_q;
    logic [3:0] irq_d;
    logic [3:0] flags;
    logic [7:0] flag_view;
    logic [3:0] clr;
    logic p0_wr;
    logic p2_wr;
    logic p3_wr;
    logic en_wr;
    logic flag_wr;
    logic p0_rd;
    logic p2_rd;
    logic p3_rd;
    logic en_rd;
    logic flag_rd;
    ////////////////////////////////////////////////////////////////
    // address decode
    assign p0_wr = hits(bus.wr, bus.addr, wake_irq_pkg::port0_wake_enable_offset);
    assign p2_wr = hits(bus.wr, bus.addr, wake_irq_pkg::port2_wake_enable_offset);
    assign p3_wr = hits(bus.wr, bus.addr, wake_irq_pkg::port3_wake_enable_offset);
    assign en_wr = hits(bus.wr, bus.addr, wake_irq_pkg::secondary_irq_enable_offset);
    assign flag_wr = hits(bus.wr, bus.addr, wake_irq_pkg::secondary_irq_flags_offset);
    assign p0_rd = hits(bus.rd, bus.addr, wake_irq_pkg::port0_wake_enable_offset);
    assign p2_rd = hits(bus.rd, bus.addr, wake_irq_pkg::port2_wake_enable_offset);
    assign p3_rd = hits(bus.rd, bus.addr, wake_irq_pkg::port3_wake_enable_offset);
    assign en_rd = hits(bus.rd, bus.addr, wake_irq_pkg::secondary_irq_enable_offset);
    assign flag_rd = hits(bus.rd, bus.addr, wake_irq_pkg::secondary_irq_flags_offset);
    ////////////////////////////////////////////////////////////////
    // flag register: zero bits of a write clear
    assign clr[3] = flag_wr && !bus.wdata[wake_irq_pkg::pwm_group_bit];
    assign clr[2] = flag_wr && !bus.wdata[wake_irq_pkg::pwm_first_bit];
    assign clr[1] = flag_wr && !bus.wdata[wake_irq_pkg::touch_b_bit];
    assign clr[0] = flag_wr && !bus.wdata[wake_irq_pkg::touch_a_bit];
    for (genvar i = 0; i < 4; i++) begin : g_flag
        flag_cell i_flag_cell (
            .clk(clk),
            .resetn(resetn),
            .set(bus.period_end[i]),
            .clr(clr[i]),
            .flag_q(flags[i])
        );
    end
    assign flag_view = place_sources(flags);
    ////////////////////////////////////////////////////////////////
    // port 0 wake enables
    always_comb begin
        p0_d = p0_q;
        if (p0_wr) begin
            p0_d = bus.wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            p0_q <= wake_irq_pkg::wake_enable_reset;
        end else begin
            p0_q <= p0_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // port 2 wake enables
    always_comb begin
        p2_d = p2_q;
        if (p2_wr) begin
            p2_d = bus.wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            p2_q <= wake_irq_pkg::wake_enable_reset;
        end else begin
            p2_q <= p2_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // port 3 wake enables
    always_comb begin
        p3_d = p3_q;
        if (p3_wr) begin
            p3_d = bus.wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            p3_q <= wake_irq_pkg::wake_enable_reset;
        end else begin
            p3_q <= p3_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // secondary enable register
    always_comb begin
        en_d = en_q;
        if (en_wr) begin
            en_d = bus.wdata & wake_irq_pkg::secondary_used_mask;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_q <= wake_irq_pkg::secondary_reset;
        end else begin
            en_q <= en_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // read path: data one cycle after the strobe
    always_comb begin
        rvalid_d = bus.rd;
        rdata_d = rdata_q;
        if (bus.rd) begin
            rdata_d = 8'h00;
        end
        if (p0_rd) begin
            rdata_d = p0_q;
        end
        if (p2_rd) begin
            rdata_d = p2_q;
        end
        if (p3_rd) begin
            rdata_d = p3_q;
        end
        if (en_rd) begin
            rdata_d = en_q;
        end
        if (flag_rd) begin
            rdata_d = flag_view;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // interrupt requests: flag and enable both set
    always_comb begin
        irq_d = flags & pick_sources(en_q);
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_q <= 4'h0;
        end else begin
            irq_q <= irq_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // outputs straight from registers
    assign bus.rdata = rdata_q;
    assign bus.rvalid = rvalid_q;
    assign bus.irq_req = irq_q;
    assign bus.p0_wake = p0_q;
    assign bus.p2_wake = p2_q;
    assign bus.p3_wake = p3_q;
endmodule : wake_irq_device
`default_nettype wire

// >>> rtl/wake_irq_pkg.sv
`default_nettype none
package wake_irq_pkg;
    localparam logic [7:0] port0_wake_enable_offset = 8'hC5;
    localparam logic [7:0] port2_wake_enable_offset = 8'hC6;
    localparam logic [7:0] port3_wake_enable_offset = 8'hC7;
    localparam logic [7:0] secondary_irq_enable_offset = 8'h84;
    localparam logic [7:0] secondary_irq_flags_offset = 8'h85;
    localparam logic [7:0] wake_enable_reset = 8'h00;
    localparam logic [7:0] secondary_reset = 8'h00;
    localparam int pwm_group_bit = 6;
    localparam int pwm_first_bit = 5;
    localparam int touch_b_bit = 1;
    localparam int touch_a_bit = 0;
    localparam logic [7:0] secondary_used_mask = 8'h63;
    localparam logic [7:0] clear_pwm_group = 8'hBF;
    localparam logic [7:0] clear_pwm_first = 8'hDF;
    localparam logic [7:0] clear_touch_b = 8'hFD;
    localparam logic [7:0] clear_touch_a = 8'hFE;
endpackage : wake_irq_pkg
`default_nettype wire

// >>> rtl/sfr_if.sv
`default_nettype none
interface sfr_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] period_end;
    logic [3:0] irq_req;
    logic [7:0] p0_wake;
    logic [7:0] p2_wake;
    logic [7:0] p3_wake;
    modport device (input wr, rd, addr, wdata, period_end, output rdata, rvalid, irq_req, p0_wake, p2_wake, p3_wake);
    modport host (output wr, rd, addr, wdata, period_end, input rdata, rvalid, irq_req, p0_wake, p2_wake, p3_wake);
endinterface : sfr_if
`default_nettype wire

// >>> rtl/flag_cell.sv
`default_nettype none
module flag_cell (
    input wire logic clk,
    input wire logic resetn,
    input wire logic set,
    input wire logic clr,
    output logic flag_q
);
    logic flag_d;
    always_comb begin
        flag_d = flag_q;
        if (clr) begin
            flag_d = 1'b0;
        end
        if (set) begin
            flag_d = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule : flag_cell
`default_nettype wire

// >>> rtl/wake_irq_host.sv
`default_nettype none
module wake_irq_host (
    input wire logic clk,
    input wire logic resetn,
    sfr_if.host bus,
    input wire logic req_wr,
    input wire logic req_rd,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [3:0] unit_events,
    output logic [7:0] resp_data,
    output logic resp_valid,
    output logic [3:0] irq_pending,
    output logic [23:0] wake_enables
);
    logic wr_q, rd_q;
    logic [7:0] addr_q, wdata_q, resp_q, resp_d;
    logic [3:0] ev_q, irq_q;
    logic [23:0] wake_q;
    logic resp_valid_q;
    always_comb begin
        resp_d = resp_q;
        if (bus.rvalid) begin
            resp_d = bus.rdata;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
            ev_q <= 4'h0;
            resp_q <= 8'h00;
            resp_valid_q <= 1'b0;
            irq_q <= 4'h0;
            wake_q <= 24'h000000;
        end else begin
            wr_q <= req_wr;
            rd_q <= req_rd;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            ev_q <= unit_events;
            resp_q <= resp_d;
            resp_valid_q <= bus.rvalid;
            irq_q <= bus.irq_req;
            wake_q <= {bus.p3_wake, bus.p2_wake, bus.p0_wake};
        end
    end
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.period_end = ev_q;
    assign resp_data = resp_q;
    assign resp_valid = resp_valid_q;
    assign irq_pending = irq_q;
    assign wake_enables = wake_q;
endmodule : wake_irq_host
`default_nettype wire

// >>> verification/wake_irq_properties.sv
`default_nettype none
module wake_irq_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic [3:0] period_end,
    input wire logic [3:0] irq_req,
    input wire logic [7:0] p0_wake,
    input wire logic [7:0] p2_wake,
    input wire logic [7:0] p3_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence put(logic [7:0] a);
        wr && addr == a;
    endsequence
    a_p0_write: assert property (put(8'hC5) |=> p0_wake == $past(wdata))
        else $error("p0 write");
    a_p2_write: assert property (put(8'hC6) |=> p2_wake == $past(wdata))
        else $error("p2 write");
    a_p3_write: assert property (put(8'hC7) |=> p3_wake == $past(wdata))
        else $error("p3 write");
    a_read_answer: assert property (rd |=> rvalid)
        else $error("no rvalid");
    a_unmapped_read: assert property (rd && !(addr inside {8'h84, 8'h85, 8'hC5, 8'hC6, 8'hC7}) |=> !rdata)
        else $error("unmapped");
    a_enable_unused: assert property (rd && addr == 8'h84 |=> (rdata & 8'h9C) == 8'h00)
        else $error("enable bits");
    a_group_clear: assert property (put(8'h85) ##0 !wdata[6] && !period_end[3] |=> ##1 !irq_req[3])
        else $error("group clear");
    a_irq_cause: assert property ($rose(irq_req[0]) |-> $past(period_end[0], 2) || $past(wr, 2))
        else $error("irq cause");
endmodule : wake_irq_properties
`default_nettype wire

// >>> verification/test_wake_and_irq_enable_flags.sv
`default_nettype none
module test_wake_and_irq_enable_flags;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic req_wr = 1'b0;
    logic req_rd = 1'b0;
    logic [7:0] req_addr = 8'h00;
    logic [7:0] req_wdata = 8'h00;
    logic [3:0] unit_events = 4'h0;
    logic [7:0] resp_data;
    logic resp_valid;
    logic [3:0] irq_pending;
    logic [23:0] wake_enables;
    int err_total = 0;
    int n_checks = 0;
    sfr_if bus ();
    always #10 clk = ~clk;
    wake_irq_device i_wake_irq_device (.clk(clk), .resetn(resetn), .bus(bus));
    wake_irq_host i_wake_irq_host (.clk(clk), .resetn(resetn), .bus(bus), .req_wr(req_wr), .req_rd(req_rd),
        .req_addr(req_addr), .req_wdata(req_wdata), .unit_events(unit_events), .resp_data(resp_data),
        .resp_valid(resp_valid), .irq_pending(irq_pending), .wake_enables(wake_enables));
    wake_irq_properties i_wake_irq_properties (.clk(clk), .resetn(resetn), .wr(bus.wr), .rd(bus.rd),
        .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid), .period_end(bus.period_end),
        .irq_req(bus.irq_req), .p0_wake(bus.p0_wake), .p2_wake(bus.p2_wake), .p3_wake(bus.p3_wake));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req_wr <= 1'b1;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_wr <= 1'b0;
    endtask : put
    task automatic get(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req_rd <= 1'b1;
        req_addr <= a;
        @(posedge clk);
        req_rd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("read", {16'h0001, exp}, {15'h0000, resp_valid, resp_data});
    endtask : get
    task automatic pulse(input logic [3:0] e);
        @(posedge clk);
        unit_events <= e;
        @(posedge clk);
        unit_events <= 4'h0;
        repeat (5) @(posedge clk);
        #1;
    endtask : pulse
    ////////////////////////////////////////////////////////////////
    task automatic t_wake_regs;
        get(8'hC5, 8'h00);
        put(8'hC5, 8'h5A);
        put(8'hC6, 8'hA5);
        put(8'hC7, 8'h3C);
        put(8'h86, 8'hFF);
        get(8'hC6, 8'hA5);
        get(8'h86, 8'h00);
        chk("wake", 24'h3CA55A, wake_enables);
    endtask : t_wake_regs
    task automatic t_flags;
        logic [7:0] pat [4] = '{8'hBF, 8'hDF, 8'hFD, 8'hFE};
        logic [7:0] left [4] = '{8'h23, 8'h03, 8'h01, 8'h00};
        put(8'h84, 8'hFF);
        get(8'h84, 8'h63);
        pulse(4'hF);
        chk("irq", 24'h00000F, {20'h0, irq_pending});
        put(8'h85, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            put(8'h85, pat[i]);
            get(8'h85, left[i]);
        end
        put(8'h84, 8'h00);
        fork
            put(8'h85, 8'hFE);
            pulse(4'h1);
        join
        get(8'h85, 8'h01);
        chk("irq", 24'h0, {20'h0, irq_pending});
    endtask : t_flags
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_wake_regs();
        t_flags();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        wrap_up();
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
endmodule : test_wake_and_irq_enable_flags
`default_nettype wire
